// [common/gdc_frame_if.sv]
`timescale 1ns/10ps
interface gdc_frame_if;
	logic wr_stb;
	logic [6:0] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic crc_en;
	modport link(output wr_stb, output addr, output wdata, input rdata, input crc_en);
	modport regs(input wr_stb, input addr, input wdata, output rdata, output crc_en);
endinterface

// [common/gdc_pkg.sv]
package gdc_pkg;
	// ***********************************************************
	// Register map and field layout
	// ***********************************************************
	localparam logic [6:0] GDC_ADDR_CTRL_TWO = 7'h1B;
	localparam logic [6:0] GDC_ADDR_CTRL_THREE = 7'h1C;
	localparam logic [15:0] GDC_CTRL_TWO_RESET = 16'h0006;
	localparam logic [15:0] GDC_CTRL_THREE_RESET = 16'h8001;
	localparam int GDC_C2_PRE_EN = 15;
	localparam int GDC_C2_MODE_LSB = 6;
	localparam int GDC_C2_LOCK_LSB = 1;
	localparam int GDC_C2_CLR = 0;
	localparam int GDC_C3_CRC_EN = 15;
	localparam int GDC_C3_WARN_REP = 14;
	localparam int GDC_C3_SSC_OFF = 12;
	localparam int GDC_C3_TRK_DLY = 10;
	localparam int GDC_C3_OT_LSB = 0;
	// Lock codes; any other code leaves the lock state alone
	localparam logic [2:0] GDC_LOCK_ON = 3'h6;
	localparam logic [2:0] GDC_LOCK_OFF = 3'h3;
	// Pump mode and overtemperature response encodings
	localparam logic [1:0] GDC_PUMP_NORMAL = 2'h0;
	localparam logic [1:0] GDC_PUMP_SW_OFF = 2'h1;
	localparam logic [1:0] GDC_PUMP_SHUT = 2'h2;
	localparam logic [1:0] GDC_PUMP_TSW_OFF = 2'h3;
	localparam logic [1:0] GDC_OT_WARN = 2'h0;
	localparam logic [1:0] GDC_OT_FAULT = 2'h1;
	// ***********************************************************
	// Frame format and timing
	// ***********************************************************
	localparam logic [5:0] GDC_FRAME_PLAIN = 6'h18;
	localparam logic [5:0] GDC_FRAME_CRC = 6'h20;
	localparam logic [5:0] GDC_CMD_LAST_BIT = 6'h07;
	localparam logic [5:0] GDC_DATA_FIRST = 6'h08;
	localparam int GDC_CLK_MHZ = 10;
	localparam int GDC_TRK_SHORT_US = 100;
	localparam int GDC_TRK_LONG_US = 250;
	localparam logic [11:0] GDC_TRK_SHORT_CYC = 12'(GDC_TRK_SHORT_US * GDC_CLK_MHZ);
	localparam logic [11:0] GDC_TRK_LONG_CYC = 12'(GDC_TRK_LONG_US * GDC_CLK_MHZ);
endpackage

// [src/gdc_ctrl_regs.sv]
`timescale 1ns/10ps
module gdc_ctrl_regs
	import gdc_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire logic driver_off_pin,
	input wire logic [2:0] high_side_in,
	input wire logic [2:0] low_side_in,
	input wire logic shutdown_fault,
	input wire logic warn_event,
	input wire logic overtemp_event,
	output logic [2:0] gate_high_out,
	output logic [2:0] gate_low_out,
	output logic fault_out_n,
	output logic fault_out_n_oe,
	output logic gate_pump_en,
	output logic pump_clk_en,
	output logic pump_to_phase_switch,
	output logic trickle_switch,
	output logic trickle_pump_run,
	output logic spread_clock_off,
	output logic predriver_en
);
	typedef struct packed {
		logic pre_en;
		logic [1:0] pump_mode_sel;
		logic locked;
		logic crc_en;
		logic warn_rep;
		logic ssc_off;
		logic trk_dly;
		logic [1:0] ot_resp;
		logic fault;
		logic warn;
		logic [11:0] idle_cnt;
		logic trk_run;
		logic [2:0] gh;
		logic [2:0] gl;
		logic fault_n;
	} gdc_regs_state_type;

	gdc_regs_state_type s_q, s_d;
	gdc_frame_if frm();
	logic wr_two, wr_three, clr, fault_set, warn_set, idle;
	logic [2:0] lock_code;
	logic [11:0] trk_target;

	// ***********************************************************
	// Serial frame receiver
	// ***********************************************************
	gdc_spi_frame u_frame (
		.clock(clock),
		.reset(reset),
		.sclk(sclk),
		.cs_n(cs_n),
		.sdi(sdi),
		.sdo(sdo),
		.sdo_oe(sdo_oe),
		.frm(frm.link)
	);

	assign frm.crc_en = s_q.crc_en;

	// Read-back; reserved and unmodelled bits read as zero
	always_comb begin
		frm.rdata = 16'h0000;
		if (frm.addr == GDC_ADDR_CTRL_TWO) begin
			frm.rdata[GDC_C2_PRE_EN] = s_q.pre_en;
			frm.rdata[GDC_C2_MODE_LSB +: 2] = s_q.pump_mode_sel;
			frm.rdata[GDC_C2_LOCK_LSB +: 3] = s_q.locked ? GDC_LOCK_ON : GDC_LOCK_OFF;
		end else if (frm.addr == GDC_ADDR_CTRL_THREE) begin
			frm.rdata[GDC_C3_CRC_EN] = s_q.crc_en;
			frm.rdata[GDC_C3_WARN_REP] = s_q.warn_rep;
			frm.rdata[GDC_C3_SSC_OFF] = s_q.ssc_off;
			frm.rdata[GDC_C3_TRK_DLY] = s_q.trk_dly;
			frm.rdata[GDC_C3_OT_LSB +: 2] = s_q.ot_resp;
		end
	end

	// ***********************************************************
	// Register and fault state
	// ***********************************************************
	always_comb begin
		s_d = s_q;
		wr_two = frm.wr_stb && frm.addr == GDC_ADDR_CTRL_TWO;
		wr_three = frm.wr_stb && frm.addr == GDC_ADDR_CTRL_THREE;
		lock_code = frm.wdata[GDC_C2_LOCK_LSB +: 3];
		// Clear is a write like any other, so a lock blocks it too
		clr = wr_two && !s_q.locked && frm.wdata[GDC_C2_CLR];
		fault_set = shutdown_fault || (overtemp_event && s_q.ot_resp == GDC_OT_FAULT);
		warn_set = warn_event || (overtemp_event && s_q.ot_resp == GDC_OT_WARN);
		// A new event in the clearing cycle survives the clear
		s_d.fault = fault_set || (s_q.fault && !clr);
		s_d.warn = warn_set || (s_q.warn && !clr);
		if (wr_two) begin
			if (lock_code == GDC_LOCK_ON) begin
				s_d.locked = 1'b1;
			end else if (lock_code == GDC_LOCK_OFF) begin
				s_d.locked = 1'b0;
			end
			if (!s_q.locked) begin
				s_d.pump_mode_sel = frm.wdata[GDC_C2_MODE_LSB +: 2];
				// Enable judged against the fault held before this frame's clear
				s_d.pre_en = frm.wdata[GDC_C2_PRE_EN] && !s_q.fault;
			end
		end
		if (wr_three && !s_q.locked) begin
			s_d.crc_en = frm.wdata[GDC_C3_CRC_EN];
			s_d.warn_rep = frm.wdata[GDC_C3_WARN_REP];
			s_d.ssc_off = frm.wdata[GDC_C3_SSC_OFF];
			s_d.trk_dly = frm.wdata[GDC_C3_TRK_DLY];
			s_d.ot_resp = frm.wdata[GDC_C3_OT_LSB +: 2];
		end
		// Hardware forces the enable off while a fault or driver-off holds
		if (s_q.fault || fault_set || driver_off_pin) begin
			s_d.pre_en = 1'b0;
		end
		// Trickle pump waits for a quiet period on every gate input
		idle = !(|high_side_in) && !(|low_side_in);
		trk_target = s_q.trk_dly ? GDC_TRK_LONG_CYC : GDC_TRK_SHORT_CYC;
		if (!idle) begin
			s_d.idle_cnt = 12'h000;
			s_d.trk_run = 1'b0;
		end else if (s_q.idle_cnt != trk_target) begin
			s_d.idle_cnt = s_q.idle_cnt + 12'h001;
		end else begin
			s_d.trk_run = 1'b1;
		end
		// Gate outputs follow the inputs only while enabled
		s_d.gh = s_d.pre_en ? high_side_in : 3'h0;
		s_d.gl = s_d.pre_en ? low_side_in : 3'h0;
		s_d.fault_n = !(s_d.fault || (s_d.warn && s_d.warn_rep));
	end

	// State register, reset values taken from the documented reset words
	always_ff @(posedge clock) begin
		if (reset) begin
			s_q <= '{pre_en: GDC_CTRL_TWO_RESET[GDC_C2_PRE_EN],
				pump_mode_sel: GDC_CTRL_TWO_RESET[GDC_C2_MODE_LSB +: 2],
				locked: GDC_CTRL_TWO_RESET[GDC_C2_LOCK_LSB +: 3] == GDC_LOCK_ON,
				crc_en: GDC_CTRL_THREE_RESET[GDC_C3_CRC_EN],
				warn_rep: GDC_CTRL_THREE_RESET[GDC_C3_WARN_REP],
				ssc_off: GDC_CTRL_THREE_RESET[GDC_C3_SSC_OFF],
				trk_dly: GDC_CTRL_THREE_RESET[GDC_C3_TRK_DLY],
				ot_resp: GDC_CTRL_THREE_RESET[GDC_C3_OT_LSB +: 2],
				fault: 1'b0, warn: 1'b0, idle_cnt: 12'h000, trk_run: 1'b0,
				gh: 3'h0, gl: 3'h0, fault_n: 1'b1};
		end else begin
			s_q <= s_d;
		end
	end

	// ***********************************************************
	// Pump and pin outputs
	// ***********************************************************
	// Mode 10 is the only one that stops the pump clock
	assign pump_clk_en = s_q.pump_mode_sel != GDC_PUMP_SHUT;
	assign gate_pump_en = s_q.pump_mode_sel != GDC_PUMP_SHUT;
	assign pump_to_phase_switch = s_q.pump_mode_sel == GDC_PUMP_NORMAL ||
		s_q.pump_mode_sel == GDC_PUMP_TSW_OFF;
	// Mode 00 keeps the switch closed so bootstrap caps stay topped up
	assign trickle_switch = s_q.pump_mode_sel == GDC_PUMP_NORMAL ||
		(s_q.pump_mode_sel == GDC_PUMP_TSW_OFF && s_q.pre_en);
	assign trickle_pump_run = s_q.trk_run && gate_pump_en;
	assign spread_clock_off = s_q.ssc_off;
	assign predriver_en = s_q.pre_en;
	assign gate_high_out = s_q.gh;
	assign gate_low_out = s_q.gl;
	// Open-drain: only ever drives low
	assign fault_out_n = 1'b0;
	assign fault_out_n_oe = !s_q.fault_n;

	// ***********************************************************
	// Checks
	// ***********************************************************
	default clocking gdc_cb @(posedge clock);
	endclocking
	default disable iff (reset);

	AST_PUMP_NORMAL: assert property (
		s_q.pump_mode_sel == GDC_PUMP_NORMAL && !s_q.pre_en |-> trickle_switch && pump_clk_en)
		else $error("mode 00 with enable low must close trickle switch");
	AST_PUMP_SW_OFF: assert property (
		s_q.pump_mode_sel == GDC_PUMP_SW_OFF |-> !pump_to_phase_switch && pump_clk_en)
		else $error("mode 01 must open phase switch and keep clock");
	AST_PUMP_SHUT: assert property (
		s_q.pump_mode_sel == GDC_PUMP_SHUT |-> !pump_to_phase_switch && !pump_clk_en)
		else $error("mode 10 must open phase switch and stop clock");
	AST_PUMP_TSW_OFF: assert property (
		s_q.pump_mode_sel == GDC_PUMP_TSW_OFF && !s_q.pre_en |-> !trickle_switch && gate_pump_en)
		else $error("mode 11 with enable low must open trickle switch");
	AST_LOCK_HOLD: assert property (
		s_q.locked && frm.wr_stb |=> $stable(s_q.pump_mode_sel) && $stable(s_q.crc_en))
		else $error("locked registers changed by a write");
	AST_LOCK_OTHER: assert property (
		wr_two && lock_code != GDC_LOCK_ON && lock_code != GDC_LOCK_OFF |=> $stable(s_q.locked))
		else $error("undefined lock code changed lock state");
	AST_CLR_FAULT: assert property (
		clr && !fault_set |=> !s_q.fault)
		else $error("fault clear did not clear latched fault");
	AST_CLR_PRIO: assert property (
		wr_two && frm.wdata[GDC_C2_PRE_EN] && frm.wdata[GDC_C2_CLR] && s_q.fault |=> !s_q.pre_en)
		else $error("enable set in same frame as clear of latched fault");
	AST_WARN_PIN: assert property (
		warn_event && !s_q.fault && !fault_set && !s_q.warn_rep && !wr_three
		|=> s_q.warn ##0 !fault_out_n_oe)
		else $error("warning drove fault pin without reporting enabled");
	AST_TRK_DELAY: assert property (
		$rose(s_q.trk_run) |-> $past(idle) && s_q.idle_cnt == trk_target)
		else $error("trickle pump started before delay elapsed");
	AST_OT_IGNORE: assert property (
		s_q.ot_resp[1] && overtemp_event && !shutdown_fault && !s_q.fault |=> !s_q.fault)
		else $error("ignored overtemperature raised a fault");
	AST_GATE_LOW: assert property (
		!s_q.pre_en |-> gate_high_out == 3'h0 && gate_low_out == 3'h0)
		else $error("gate outputs active with predriver disabled");

	// ***********************************************************
	// Field and pin checks
	// ***********************************************************
	// Lock code always takes effect, even from a locked state
	AST_LOCK_SET: assert property (
		wr_two && lock_code == GDC_LOCK_ON |=> s_q.locked)
		else $error("lock code did not lock the registers");
	// Unlock must work while locked, else the part is stuck for good
	AST_UNLOCK: assert property (
		wr_two && lock_code == GDC_LOCK_OFF |=> !s_q.locked)
		else $error("unlock code did not unlock the registers");
	// Second register is guarded by the same lock
	AST_LOCK_THREE: assert property (
		s_q.locked && wr_three |=> $stable(s_q.warn_rep) && $stable(s_q.ssc_off)
		&& $stable(s_q.trk_dly) && $stable(s_q.ot_resp))
		else $error("locked second register changed by a write");
	// Warning flag drops with the clear when no new warning arrives
	AST_CLR_WARN: assert property (
		clr && !warn_set |=> !s_q.warn)
		else $error("fault clear left warning flag set");
	// Flags are set whatever the reporting bit says
	AST_WARN_FLAG: assert property (
		warn_event |=> s_q.warn)
		else $error("warning event did not set its flag");
	// With reporting on, a held warning must pull the pin
	AST_WARN_REPORT: assert property (
		s_q.warn && s_q.warn_rep |-> fault_out_n_oe)
		else $error("reported warning left fault pin released");
	// Shutdown mode latches a fault and pulls the pin
	AST_OT_FAULT: assert property (
		overtemp_event && s_q.ot_resp == GDC_OT_FAULT |=> s_q.fault && fault_out_n_oe)
		else $error("overtemperature in shutdown mode did not latch a fault");
	// Warning mode sets the warning flag
	AST_OT_WARN: assert property (
		overtemp_event && s_q.ot_resp == GDC_OT_WARN |=> s_q.warn)
		else $error("overtemperature in warning mode did not set warning flag");
	// Oscillator control follows an accepted write one cycle later
	AST_SSC_FOLLOW: assert property (
		wr_three && !s_q.locked |=> spread_clock_off == $past(frm.wdata[GDC_C3_SSC_OFF]))
		else $error("spread clock control did not follow its write");
	// Frame format switches with the accepted write, not before
	AST_CRC_FMT: assert property (
		wr_three && !s_q.locked |=> frm.crc_en == $past(frm.wdata[GDC_C3_CRC_EN]))
		else $error("frame check enable did not follow its write");
	// Any gate activity restarts the quiet-period timer
	AST_TRK_WAIT: assert property (
		!idle |=> !trickle_pump_run && s_q.idle_cnt == 12'h000)
		else $error("trickle timer not restarted by gate activity");
	// Pump shutdown also holds the trickle pump off
	AST_TRK_SHUT: assert property (
		s_q.pump_mode_sel == GDC_PUMP_SHUT |-> !trickle_pump_run && !gate_pump_en)
		else $error("pump running in shutdown mode");
	// Enabled gates copy the inputs with one cycle of latency
	AST_GATE_PASS: assert property (
		s_q.pre_en |-> gate_high_out == $past(high_side_in)
		&& gate_low_out == $past(low_side_in))
		else $error("enabled gate outputs do not follow inputs");
	// Driver-off pin overrides a written enable from the next cycle
	AST_DRIVER_OFF_PIN: assert property (
		driver_off_pin |=> !predriver_en && gate_high_out == 3'h0 && gate_low_out == 3'h0)
		else $error("driver-off pin did not disable the gates");
	// Reserved and unmodelled bits of the first register read zero
	AST_RSVD_TWO: assert property (
		frm.addr == GDC_ADDR_CTRL_TWO |-> frm.rdata[14:8] == 7'h00 && frm.rdata[5:4] == 2'h0
		&& !frm.rdata[GDC_C2_CLR])
		else $error("reserved bits of first register read nonzero");
	// Reserved bits of the second register read zero
	AST_RSVD_THREE: assert property (
		frm.addr == GDC_ADDR_CTRL_THREE |-> frm.rdata[13] == 1'b0 && frm.rdata[11] == 1'b0
		&& frm.rdata[9:2] == 8'h00)
		else $error("reserved bits of second register read nonzero");

	COV_LOCK_CYCLE: cover property (s_q.locked ##[1:200] !s_q.locked);
	COV_CLR_THEN_EN: cover property (s_q.fault ##1 !s_q.fault ##[1:200] s_q.pre_en);
	COV_TRK_START: cover property ($rose(trickle_pump_run));
	COV_WARN_PIN: cover property (s_q.warn && s_q.warn_rep && fault_out_n_oe);
	COV_OT_SHUT: cover property (overtemp_event && s_q.ot_resp == GDC_OT_FAULT);
endmodule

// [src/gdc_spi_frame.sv]
`timescale 1ns/10ps
module gdc_spi_frame
	import gdc_pkg::*;
#(
	parameter logic [7:0] CRC_POLY = 8'h07
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	gdc_frame_if.link frm
);
	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic [5:0] cnt;
		logic [31:0] sh;
		logic [15:0] tx;
		logic [6:0] addr;
		logic rd;
		logic wr_stb;
		logic [15:0] wdata;
	} gdc_spi_state_type;

	gdc_spi_state_type s_q, s_d;
	logic rise, fall, frame_ok;

	// CRC over command and data, most significant bit first
	function automatic logic [7:0] gdc_crc8(input logic [23:0] msg);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			if (c[7] ^ msg[i]) begin
				c = {c[6:0], 1'b0} ^ CRC_POLY;
			end else begin
				c = {c[6:0], 1'b0};
			end
		end
		return c;
	endfunction

	// ***********************************************************
	// Frame shifter
	// ***********************************************************
	// Length must match the selected format exactly, else the frame is dropped
	always_comb begin
		rise = !s_q.sclk && sclk && !cs_n;
		fall = s_q.sclk && !sclk && !cs_n;
		frame_ok = frm.crc_en ? (s_q.cnt == GDC_FRAME_CRC &&
			gdc_crc8(s_q.sh[31:8]) == s_q.sh[7:0]) : (s_q.cnt == GDC_FRAME_PLAIN);
		s_d = s_q;
		s_d.sclk = sclk;
		s_d.cs_n = cs_n;
		s_d.wr_stb = 1'b0;
		if (!cs_n && s_q.cs_n) begin
			s_d.cnt = 6'h00;
			s_d.tx = 16'h0000;
		end else if (cs_n && !s_q.cs_n) begin
			if (frame_ok && !s_q.rd) begin
				s_d.wr_stb = 1'b1;
				s_d.wdata = frm.crc_en ? s_q.sh[23:8] : s_q.sh[15:0];
			end
		end else begin
			if (rise) begin
				s_d.sh = {s_q.sh[30:0], sdi};
				if (s_q.cnt != 6'h3F) begin
					s_d.cnt = s_q.cnt + 6'h01;
				end
				if (s_q.cnt == GDC_CMD_LAST_BIT) begin
					s_d.rd = s_q.sh[6];
					s_d.addr = {s_q.sh[5:0], sdi};
				end
			end
			// Read data is launched on the falling edge after the command byte
			if (fall) begin
				if (s_q.cnt == GDC_DATA_FIRST) begin
					s_d.tx = frm.rdata;
				end else begin
					s_d.tx = {s_q.tx[14:0], 1'b0};
				end
			end
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (reset) begin
			s_q <= '{sclk: 1'b0, cs_n: 1'b1, cnt: 6'h00, sh: 32'h00000000, tx: 16'h0000,
				addr: 7'h00, rd: 1'b0, wr_stb: 1'b0, wdata: 16'h0000};
		end else begin
			s_q <= s_d;
		end
	end

	assign sdo = s_q.tx[15];
	assign sdo_oe = !s_q.cs_n;
	assign frm.wr_stb = s_q.wr_stb;
	assign frm.addr = s_q.addr;
	assign frm.wdata = s_q.wdata;

	// A write strobe only follows a frame of the length the format demands
	AST_FRAME_LEN: assert property (@(posedge clock) disable iff (reset)
		s_q.wr_stb |-> $past(s_q.cnt) == (frm.crc_en ? GDC_FRAME_CRC : GDC_FRAME_PLAIN))
		else $error("write strobe after frame of wrong length");
endmodule

// [tb/gate_driver_ctrl_regs_tb.sv]
`timescale 1ns/10ps
module gate_driver_ctrl_regs_tb import gdc_pkg::*; ;
	logic clock, reset, sclk, cs_n, sdi, sdo, sdo_oe, driver_off_pin;
	logic [2:0] high_side_in, low_side_in, gate_high_out, gate_low_out;
	logic shutdown_fault, warn_event, overtemp_event, fault_out_n, fault_out_n_oe;
	logic gate_pump_en, pump_clk_en, pump_to_phase_switch, trickle_switch;
	logic trickle_pump_run, spread_clock_off, predriver_en, mon_stb, crc_on;
	logic [15:0] exp_q[$];
	logic [15:0] mon_val, rd;
	int failures, samples_checked, seed, n;
	wire logic [15:0] st = {sdo_oe, fault_out_n, gate_high_out, gate_low_out, fault_out_n_oe,
		gate_pump_en,
		pump_clk_en, pump_to_phase_switch, trickle_switch, trickle_pump_run, spread_clock_off,
		predriver_en};

	// 10 MHz clock
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	gdc_ctrl_regs uut (.clock(clock), .reset(reset), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
		.sdo(sdo), .sdo_oe(sdo_oe), .driver_off_pin(driver_off_pin),
		.high_side_in(high_side_in), .low_side_in(low_side_in),
		.shutdown_fault(shutdown_fault), .warn_event(warn_event),
		.overtemp_event(overtemp_event), .gate_high_out(gate_high_out),
		.gate_low_out(gate_low_out), .fault_out_n(fault_out_n),
		.fault_out_n_oe(fault_out_n_oe), .gate_pump_en(gate_pump_en),
		.pump_clk_en(pump_clk_en), .pump_to_phase_switch(pump_to_phase_switch),
		.trickle_switch(trickle_switch), .trickle_pump_run(trickle_pump_run),
		.spread_clock_off(spread_clock_off), .predriver_en(predriver_en));

	gdc_spi_master master (.clock(clock), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

	// ***********************************************************
	// Checking
	// ***********************************************************
	task check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Each presented result is matched against the oldest note
	always @(posedge clock) begin
		if (mon_stb === 1'b1) check(mon_val, exp_q.pop_front());
	end

	task post(input logic [15:0] v, input logic [15:0] e);
		exp_q.push_back(e);
		@(negedge clock);
		mon_val = v;
		mon_stb = 1'b1;
		@(negedge clock);
		mon_stb = 1'b0;
	endtask

	task complete_run;
		$display("Checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Frame format follows the last ctrl_three write; never written while locked
	task wr(input logic [6:0] a, input logic [15:0] d);
		master.xfer({1'b0, a}, d, crc_on, rd);
		if (a == GDC_ADDR_CTRL_THREE) crc_on = d[15];
	endtask

	task rdc(input logic [6:0] a, input logic [15:0] e);
		master.xfer({1'b1, a}, 16'h0000, crc_on, rd);
		post(rd, e);
	endtask

	task stc(input logic [1:0] m, input logic en, input logic oe, input logic ss);
		post(st, {2'h0, en ? high_side_in : 3'h0, en ? low_side_in : 3'h0, oe, m != 2'h2,
			m != 2'h2, m == 2'h0 || m == 2'h3, m == 2'h0 || (m == 2'h3 && en), 1'b0, ss, en});
	endtask

	// One-cycle event pulse: {shutdown, warning, overtemp}
	task ev(input logic [2:0] k);
		{shutdown_fault, warn_event, overtemp_event} = k;
		@(negedge clock);
		{shutdown_fault, warn_event, overtemp_event} = 3'h0;
		repeat (2) @(negedge clock);
	endtask

	// ***********************************************************
	// Main sequence
	// ***********************************************************
	initial begin
		seed = 61820;
		failures = 0;
		samples_checked = 0;
		crc_on = 1'b1;
		mon_stb = 1'b0;
		mon_val = 16'h0000;
		reset = 1'b1;
		driver_off_pin = 1'b0;
		{shutdown_fault, warn_event, overtemp_event} = 3'h0;
		high_side_in = 3'h1;
		low_side_in = 3'h0;
		repeat (12) @(negedge clock);
		reset = 1'b0;
		@(negedge clock);
		rdc(GDC_ADDR_CTRL_TWO, 16'h0006);
		rdc(GDC_ADDR_CTRL_THREE, 16'h8001);
		rdc(7'h10, 16'h0000);
		stc(2'h0, 1'b0, 1'b0, 1'b0);
		wr(GDC_ADDR_CTRL_THREE, 16'h7FFC);
		rdc(GDC_ADDR_CTRL_THREE, 16'h5400);
		stc(2'h0, 1'b0, 1'b0, 1'b1);
		$display("Test frame format and reserved bits done");
		for (int en = 0; en < 2; en++) begin
			for (int m = 0; m < 4; m++) begin
				high_side_in = 3'($random(seed)) | 3'h1;
				low_side_in = 3'($random(seed));
				wr(GDC_ADDR_CTRL_TWO, {1'(en), 7'h00, 2'(m), 6'h06});
				stc(2'(m), 1'(en), 1'b0, 1'b1);
			end
		end
		$display("Test pump modes done");
		wr(GDC_ADDR_CTRL_TWO, 16'h000C);
		rdc(GDC_ADDR_CTRL_TWO, 16'h000C);
		wr(GDC_ADDR_CTRL_TWO, 16'h80CC);
		rdc(GDC_ADDR_CTRL_TWO, 16'h000C);
		// Locked write to the second register; format must not change
		master.xfer({1'b0, GDC_ADDR_CTRL_THREE}, 16'h8000, crc_on, rd);
		rdc(GDC_ADDR_CTRL_THREE, 16'h5400);
		wr(GDC_ADDR_CTRL_TWO, 16'h0002);
		rdc(GDC_ADDR_CTRL_TWO, 16'h000C);
		wr(GDC_ADDR_CTRL_TWO, 16'h0006);
		rdc(GDC_ADDR_CTRL_TWO, 16'h0006);
		// Driver-off high in mode 00: enable refused, trickle switch stays closed
		driver_off_pin = 1'b1;
		wr(GDC_ADDR_CTRL_TWO, 16'h8006);
		stc(2'h0, 1'b0, 1'b0, 1'b1);
		driver_off_pin = 1'b0;
		$display("Test lock done");
		for (int d = 0; d < 2; d++) begin
			wr(GDC_ADDR_CTRL_THREE, {5'h00, 1'(d), 10'h000});
			high_side_in = 3'h0;
			low_side_in = 3'h0;
			n = 0;
			while (trickle_pump_run !== 1'b1 && n < 3000) begin
				@(negedge clock);
				n++;
			end
			rd = d ? GDC_TRK_LONG_CYC : GDC_TRK_SHORT_CYC;
			post(16'(n >= rd && n <= rd + 3), 16'h0001);
			if (n >= 3000) complete_run();
			high_side_in = 3'h1;
		end
		$display("Test trickle delay done");
		ev(3'h4);
		stc(2'h0, 1'b0, 1'b1, 1'b0);
		wr(GDC_ADDR_CTRL_TWO, 16'h8007);
		stc(2'h0, 1'b0, 1'b0, 1'b0);
		rdc(GDC_ADDR_CTRL_TWO, 16'h0006);
		wr(GDC_ADDR_CTRL_TWO, 16'h8006);
		stc(2'h0, 1'b1, 1'b0, 1'b0);
		wr(GDC_ADDR_CTRL_TWO, 16'h0006);
		for (int w = 0; w < 2; w++) begin
			for (int m = 0; m < 4; m++) begin
				wr(GDC_ADDR_CTRL_THREE, {1'b0, 1'(w), 12'h000, 2'(m)});
				ev(3'h2);
				stc(2'h0, 1'b0, 1'(w), 1'b0);
				wr(GDC_ADDR_CTRL_TWO, 16'h0007);
				ev(3'h1);
				stc(2'h0, 1'b0, m == 1 || (m == 0 && w == 1), 1'b0);
				wr(GDC_ADDR_CTRL_TWO, 16'h0007);
			end
		end
		$display("Test faults and warnings done");
		complete_run();
	end
endmodule

// [tb/gdc_spi_master.sv]
`timescale 1ns/10ps
// Controller model on the serial link; sclk stands low outside frames
module gdc_spi_master (
	clock,
	sclk,
	cs_n,
	sdi,
	sdo
);
	input wire logic clock;
	output logic sclk;
	output logic cs_n;
	output logic sdi;
	input wire logic sdo;

	// Idle link at time zero
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		sdi = 1'b0;
	end

	// One whole frame, two clocks per sclk phase; CRC byte only when enabled
	task automatic xfer(input logic [7:0] cmd, input logic [15:0] dat, input logic crc_on,
		output logic [15:0] rd);
		logic [23:0] w;
		logic [31:0] fr;
		logic [7:0] crc;
		logic fb;
		int n;
		w = {cmd, dat};
		crc = 8'h00;
		for (int i = 23; i >= 0; i--) begin
			fb = crc[7] ^ w[i];
			crc = {crc[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
		end
		n = crc_on ? 32 : 24;
		fr = {cmd, dat, crc};
		rd = 16'h0000;
		@(negedge clock);
		cs_n = 1'b0;
		repeat (2) @(negedge clock);
		for (int i = 0; i < n; i++) begin
			sdi = fr[31 - i];
			repeat (2) @(negedge clock);
			if (i >= 8 && i < 24) rd = {rd[14:0], sdo};
			sclk = 1'b1;
			repeat (2) @(negedge clock);
			sclk = 1'b0;
		end
		repeat (2) @(negedge clock);
		cs_n = 1'b1;
		// Released data line shows the inverse so a stale bit is never trusted
		sdi = ~sdi;
		repeat (3) @(negedge clock);
	endtask
endmodule
